//--- hdl/pxb_bus_seq.sv
// Package of shared constants and the external memory cycle sequencer
`timescale 1ns/1ns
`default_nettype none

package pxb_pkg;
  localparam int          PXB_W          = 8;
  localparam int          PXB_AW         = 16;
  localparam logic [7:0]  PXB_DIR_RST    = 8'h00;
  localparam logic [7:0]  PXB_SEL_RST    = 8'h00;
  localparam logic [7:0]  PXB_DATA_RST   = 8'h00;
  localparam logic [7:0]  PXB_ALL_ONES   = 8'hFF;
  localparam int          PXB_C_TXD      = 0;
  localparam int          PXB_C_RXD      = 1;
  localparam int          PXB_C_SCK      = 2;
  localparam int          PXB_C_INT      = 3;
  localparam int          PXB_C_TO       = 4;
  localparam int          PXB_C_CI       = 5;
  localparam int          PXB_C_CO0      = 6;
  localparam int          PXB_C_CO1      = 7;
  localparam int          PXB_CLK_NS     = 100;
  localparam int          PXB_ALE_NS     = 100;
  localparam int          PXB_STB_NS     = 200;
  localparam int          PXB_ALE_CYC    = (PXB_ALE_NS + PXB_CLK_NS - 1) / PXB_CLK_NS;
  localparam int          PXB_STB_CYC    = (PXB_STB_NS + PXB_CLK_NS - 1) / PXB_CLK_NS;
  localparam logic [3:0]  PXB_ALE_LAST   = 4'(PXB_ALE_CYC - 1);
  localparam logic [3:0]  PXB_STB_LAST   = 4'(PXB_STB_CYC - 1);
  localparam logic [3:0]  PXB_CNT_ZERO   = 4'h0;
  typedef enum logic [1:0] {PXB_IDLE, PXB_ADDR, PXB_STRB} pxb_bus_e;
endpackage : pxb_pkg

module pxb_bus_seq (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       busReq,
  input  wire logic                       busWrite,
  input  wire logic [pxb_pkg::PXB_AW-1:0] busAddr,
  input  wire logic [pxb_pkg::PXB_W-1:0]  busWData,
  input  wire logic [pxb_pkg::PXB_W-1:0]  adIn,
  output logic      [pxb_pkg::PXB_W-1:0]  busRData,
  output logic                            busDone,
  output logic                            busBusy,
  output logic                            ale,
  output logic                            rdN,
  output logic                            wrN,
  output logic      [pxb_pkg::PXB_W-1:0]  lowAdOut,
  output logic                            lowAdOe,
  output logic      [pxb_pkg::PXB_W-1:0]  highAddr
);
  import pxb_pkg::*;

  typedef struct packed {
    pxb_bus_e   st;
    logic [3:0] cnt;
    logic       write;
    logic [7:0] wdata;
    logic       ale;
    logic       rdN;
    logic       wrN;
    logic [7:0] adOut;
    logic       adOe;
    logic [7:0] hi;
    logic [7:0] rdata;
    logic       done;
    logic       busy;
  } pxb_seq_s;

  pxb_seq_s s_q;
  pxb_seq_s s_d;

  // ****************************************
  // Cycle sequencing
  // ****************************************
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      PXB_IDLE: begin
        if (busReq) begin
          s_d.st    = PXB_ADDR;
          s_d.write = busWrite;
          s_d.wdata = busWData;
          s_d.ale   = 1'b1;
          s_d.adOut = busAddr[7:0];
          s_d.adOe  = 1'b1;
          s_d.hi    = busAddr[15:8];
          s_d.cnt   = PXB_ALE_LAST;
          s_d.busy  = 1'b1;
        end
      end
      PXB_ADDR: begin
        if (s_q.cnt == PXB_CNT_ZERO) begin
          s_d.st  = PXB_STRB;
          s_d.ale = 1'b0;
          s_d.cnt = PXB_STB_LAST;
          if (s_q.write) begin
            s_d.adOut = s_q.wdata;
            s_d.wrN   = 1'b0;
          end else begin
            s_d.adOe = 1'b0;
            s_d.rdN  = 1'b0;
          end
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      PXB_STRB: begin
        if (s_q.cnt == PXB_CNT_ZERO) begin
          if (!s_q.write) begin
            s_d.rdata = adIn;
          end
          s_d.st   = PXB_IDLE;
          s_d.rdN  = 1'b1;
          s_d.wrN  = 1'b1;
          s_d.adOe = 1'b0;
          s_d.done = 1'b1;
          s_d.busy = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: begin
        s_d.st = PXB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '{st: PXB_IDLE, cnt: PXB_CNT_ZERO, write: 1'b0, wdata: PXB_DATA_RST, ale: 1'b0, rdN: 1'b1,
               wrN: 1'b1, adOut: PXB_DATA_RST, adOe: 1'b0, hi: PXB_DATA_RST, rdata: PXB_DATA_RST,
               done: 1'b0, busy: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busRData = s_q.rdata;
  assign busDone  = s_q.done;
  assign busBusy  = s_q.busy;
  assign ale      = s_q.ale;
  assign rdN      = s_q.rdN;
  assign wrN      = s_q.wrN;
  assign lowAdOut = s_q.adOut;
  assign lowAdOe  = s_q.adOe;
  assign highAddr = s_q.hi;
endmodule : pxb_bus_seq

`default_nettype wire

//--- hdl/pxb_port_pins.sv
// Port pin multiplexer with external memory bus pins
`timescale 1ns/1ns
`default_nettype none

module pxb_port_pins (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic                       resetPinN,
  input  wire logic                       hwStopN,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portADirSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portAWrite,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portBDirSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portBWrite,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portCDirSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portCAltSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portCWrite,
  input  wire logic                       portDOutSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portDWrite,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portFDirSel,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portFWrite,
  input  wire logic                       extMemSel,
  input  wire logic                       serialClkIntSel,
  input  wire logic                       timerClkSel,
  input  wire logic                       serialTxData,
  input  wire logic                       serialClkOut,
  input  wire logic                       timerSquare,
  input  wire logic                       eventSquareA,
  input  wire logic                       eventSquareB,
  input  wire logic                       busReq,
  input  wire logic                       busWrite,
  input  wire logic [pxb_pkg::PXB_AW-1:0] busAddr,
  input  wire logic [pxb_pkg::PXB_W-1:0]  busWData,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portAPinIn,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portBPinIn,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portCPinIn,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portDPinIn,
  input  wire logic [pxb_pkg::PXB_W-1:0]  portFPinIn,
  output logic      [pxb_pkg::PXB_W-1:0]  portAPinOut,
  output logic      [pxb_pkg::PXB_W-1:0]  portAPinOe,
  output logic      [pxb_pkg::PXB_W-1:0]  portBPinOut,
  output logic      [pxb_pkg::PXB_W-1:0]  portBPinOe,
  output logic      [pxb_pkg::PXB_W-1:0]  portCPinOut,
  output logic      [pxb_pkg::PXB_W-1:0]  portCPinOe,
  output logic      [pxb_pkg::PXB_W-1:0]  portDPinOut,
  output logic      [pxb_pkg::PXB_W-1:0]  portDPinOe,
  output logic      [pxb_pkg::PXB_W-1:0]  portFPinOut,
  output logic      [pxb_pkg::PXB_W-1:0]  portFPinOe,
  output logic                            writeStrobeN,
  output logic                            writeStrobeOe,
  output logic                            readStrobeN,
  output logic                            readStrobeOe,
  output logic                            addrLatch,
  output logic                            addrLatchOe,
  output logic      [pxb_pkg::PXB_W-1:0]  portARead,
  output logic      [pxb_pkg::PXB_W-1:0]  portBRead,
  output logic      [pxb_pkg::PXB_W-1:0]  portCRead,
  output logic      [pxb_pkg::PXB_W-1:0]  portDRead,
  output logic      [pxb_pkg::PXB_W-1:0]  portFRead,
  output logic                            serialRxData,
  output logic                            serialClkIn,
  output logic                            edgeIrqTwo,
  output logic                            edgeIrqTwoLevel,
  output logic                            timerClockInput,
  output logic                            eventCountInput,
  output logic      [pxb_pkg::PXB_W-1:0]  busRData,
  output logic                            busDone,
  output logic                            busBusy
);
  import pxb_pkg::*;

  typedef struct packed {
    logic [7:0] aDir;
    logic [7:0] bDir;
    logic [7:0] cDir;
    logic [7:0] cAlt;
    logic       dOut;
    logic [7:0] fDir;
    logic       extMem;
    logic       sckInt;
    logic       tiSel;
    logic [7:0] aOut;
    logic [7:0] aOe;
    logic [7:0] bOut;
    logic [7:0] bOe;
    logic [7:0] cOut;
    logic [7:0] cOe;
    logic [7:0] dPin;
    logic [7:0] dOe;
    logic [7:0] fPin;
    logic [7:0] fOe;
    logic       wrN;
    logic       rdN;
    logic       ale;
    logic       strobeOe;
    logic [7:0] aRd;
    logic [7:0] bRd;
    logic [7:0] cRd;
    logic [7:0] dRd;
    logic [7:0] fRd;
    logic       rxd;
    logic       sckIn;
    logic       irq;
    logic       irqLvl;
    logic       irqPrev;
    logic       tiIn;
    logic       ciIn;
  } pxb_top_s;

  pxb_top_s s_q;
  pxb_top_s s_d;

  logic [7:0] seqAdOut;
  logic       seqAdOe;
  logic [7:0] seqHigh;
  logic       seqAle;
  logic       seqRdN;
  logic       seqWrN;
  logic       seqBusy;

  // ****************************************
  // Role helpers
  // ****************************************
  function automatic logic [7:0] pxb_pick(input logic [7:0] sel, input logic [7:0] alt, input logic [7:0] dflt);
    logic [7:0] r;
    r = (sel & alt) | (~sel & dflt);
    return r;
  endfunction : pxb_pick

  // ****************************************
  // External memory cycles
  // ****************************************
  pxb_bus_seq u_seq (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .busReq   (busReq & s_q.extMem & ~seqBusy),
    .busWrite (busWrite),
    .busAddr  (busAddr),
    .busWData (busWData),
    .adIn     (portDPinIn),
    .busRData (busRData),
    .busDone  (busDone),
    .busBusy  (seqBusy),
    .ale      (seqAle),
    .rdN      (seqRdN),
    .wrN      (seqWrN),
    .lowAdOut (seqAdOut),
    .lowAdOe  (seqAdOe),
    .highAddr (seqHigh)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] altOut;
    logic [7:0] altOe;
    altOut = PXB_DATA_RST;
    altOe  = PXB_DIR_RST;
    s_d    = s_q;

    s_d.aDir   = portADirSel;
    s_d.bDir   = portBDirSel;
    s_d.cDir   = portCDirSel;
    s_d.cAlt   = portCAltSel;
    s_d.dOut   = portDOutSel;
    s_d.fDir   = portFDirSel;
    s_d.extMem = extMemSel;
    s_d.sckInt = serialClkIntSel;
    s_d.tiSel  = timerClkSel;

    s_d.aOut = portAWrite;
    s_d.aOe  = s_q.aDir;
    s_d.bOut = portBWrite;
    s_d.bOe  = s_q.bDir;

    // ****************************************
    // Port C alternate roles
    // ****************************************
    altOut[PXB_C_TXD] = serialTxData;
    altOe[PXB_C_TXD]  = 1'b1;
    altOe[PXB_C_RXD]  = 1'b0;
    altOut[PXB_C_SCK] = serialClkOut;
    altOe[PXB_C_SCK]  = s_q.sckInt;
    altOe[PXB_C_INT]  = 1'b0;
    altOut[PXB_C_TO]  = timerSquare;
    altOe[PXB_C_TO]   = 1'b1;
    altOe[PXB_C_CI]   = 1'b0;
    altOut[PXB_C_CO0] = eventSquareA;
    altOe[PXB_C_CO0]  = 1'b1;
    altOut[PXB_C_CO1] = eventSquareB;
    altOe[PXB_C_CO1]  = 1'b1;
    s_d.cOut = pxb_pick(s_q.cAlt, altOut, portCWrite);
    s_d.cOe  = pxb_pick(s_q.cAlt, altOe, s_q.cDir);

    // ****************************************
    // Port D and F roles
    // ****************************************
    if (s_q.extMem) begin
      s_d.dPin = seqAdOut;
      s_d.dOe  = {PXB_W{seqAdOe}};
      s_d.fPin = seqHigh;
      s_d.fOe  = PXB_ALL_ONES;
    end else begin
      s_d.dPin = portDWrite;
      s_d.dOe  = {PXB_W{s_q.dOut}};
      s_d.fPin = portFWrite;
      s_d.fOe  = s_q.fDir;
    end

    s_d.wrN      = seqWrN;
    s_d.rdN      = seqRdN;
    s_d.ale      = seqAle;
    s_d.strobeOe = resetPinN & hwStopN;

    s_d.aRd = portAPinIn;
    s_d.bRd = portBPinIn;
    s_d.cRd = portCPinIn;
    s_d.dRd = portDPinIn;
    s_d.fRd = portFPinIn;

    // ****************************************
    // Peripheral inputs
    // ****************************************
    s_d.irqPrev = portCPinIn[PXB_C_INT];
    s_d.rxd     = 1'b1;
    s_d.sckIn   = 1'b1;
    s_d.irqLvl  = 1'b1;
    s_d.irq     = 1'b0;
    s_d.tiIn    = 1'b0;
    s_d.ciIn    = 1'b0;
    if (s_q.cAlt[PXB_C_RXD]) begin
      s_d.rxd = portCPinIn[PXB_C_RXD];
    end
    if (s_q.cAlt[PXB_C_SCK] && !s_q.sckInt) begin
      s_d.sckIn = portCPinIn[PXB_C_SCK];
    end
    if (s_q.cAlt[PXB_C_INT]) begin
      if (s_q.tiSel) begin
        s_d.tiIn = portCPinIn[PXB_C_INT];
      end else begin
        s_d.irqLvl = portCPinIn[PXB_C_INT];
        s_d.irq    = s_q.irqPrev & ~portCPinIn[PXB_C_INT];
      end
    end
    if (s_q.cAlt[PXB_C_CI]) begin
      s_d.ciIn = portCPinIn[PXB_C_CI];
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '{aDir: PXB_DIR_RST,
               bDir: PXB_DIR_RST,
               cDir: PXB_DIR_RST,
               cAlt: PXB_SEL_RST,
               dOut: 1'b0,
               fDir: PXB_DIR_RST,
               extMem: 1'b0,
               sckInt: 1'b0,
               tiSel: 1'b0,
               aOut: PXB_DATA_RST,
               aOe: PXB_DIR_RST,
               bOut: PXB_DATA_RST,
               bOe: PXB_DIR_RST,
               cOut: PXB_DATA_RST,
               cOe: PXB_DIR_RST,
               dPin: PXB_DATA_RST,
               dOe: PXB_DIR_RST,
               fPin: PXB_DATA_RST,
               fOe: PXB_DIR_RST,
               wrN: 1'b1,
               rdN: 1'b1,
               ale: 1'b0,
               strobeOe: 1'b0,
               aRd: PXB_DATA_RST,
               bRd: PXB_DATA_RST,
               cRd: PXB_DATA_RST,
               dRd: PXB_DATA_RST,
               fRd: PXB_DATA_RST,
               rxd: 1'b1,
               sckIn: 1'b1,
               irq: 1'b0,
               irqLvl: 1'b1,
               irqPrev: 1'b1,
               tiIn: 1'b0,
               ciIn: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign portAPinOut     = s_q.aOut;
  assign portAPinOe      = s_q.aOe;
  assign portBPinOut     = s_q.bOut;
  assign portBPinOe      = s_q.bOe;
  assign portCPinOut     = s_q.cOut;
  assign portCPinOe      = s_q.cOe;
  assign portDPinOut     = s_q.dPin;
  assign portDPinOe      = s_q.dOe;
  assign portFPinOut     = s_q.fPin;
  assign portFPinOe      = s_q.fOe;
  assign writeStrobeN    = s_q.wrN;
  assign writeStrobeOe   = s_q.strobeOe;
  assign readStrobeN     = s_q.rdN;
  assign readStrobeOe    = s_q.strobeOe;
  assign addrLatch       = s_q.ale;
  assign addrLatchOe     = s_q.strobeOe;
  assign portARead       = s_q.aRd;
  assign portBRead       = s_q.bRd;
  assign portCRead       = s_q.cRd;
  assign portDRead       = s_q.dRd;
  assign portFRead       = s_q.fRd;
  assign serialRxData    = s_q.rxd;
  assign serialClkIn     = s_q.sckIn;
  assign edgeIrqTwo      = s_q.irq;
  assign edgeIrqTwoLevel = s_q.irqLvl;
  assign timerClockInput = s_q.tiIn;
  assign eventCountInput = s_q.ciIn;
  assign busBusy         = seqBusy;
endmodule : pxb_port_pins

`default_nettype wire

//--- testbench/pxb_ext_mem.sv
// External memory with low address latch
`timescale 1ns/1ns
`default_nettype none
module pxb_ext_mem (
  input  wire logic                      clk_sys,
  input  wire logic [pxb_pkg::PXB_W-1:0] portDPinOut,
  input  wire logic [pxb_pkg::PXB_W-1:0] portFPinOut,
  input  wire logic                      addrLatch,
  input  wire logic                      readStrobeN,
  input  wire logic                      writeStrobeN,
  output logic      [pxb_pkg::PXB_W-1:0] memData
);
  import pxb_pkg::*;
  logic [PXB_W-1:0] lowAddr = PXB_DATA_RST;
  logic [PXB_W-1:0] lastVal = PXB_DATA_RST;
  logic [PXB_W-1:0] mem [0:65535];
  always @(posedge clk_sys) begin
    lastVal <= memData;
    if (addrLatch) begin
      lowAddr <= portDPinOut;
    end
    if (!writeStrobeN) begin
      mem[{portFPinOut, lowAddr}] <= portDPinOut;
    end
  end
  // Released bus shows a pattern that changes every cycle
  assign memData = (readStrobeN === 1'b0) ? mem[{portFPinOut, lowAddr}] : ~lastVal;
endmodule : pxb_ext_mem
`default_nettype wire

//--- testbench/pxb_port_pins_properties.sv
// Checker of pin roles and external bus strobes
`timescale 1ns/1ns
`default_nettype none
module pxb_port_pins_properties (
  input wire logic                      clk_sys,
  input wire logic                      reset,
  input wire logic                      resetPinN,
  input wire logic                      hwStopN,
  input wire logic [pxb_pkg::PXB_W-1:0] portADirSel,
  input wire logic                      portDOutSel,
  input wire logic                      extMemSel,
  input wire logic [pxb_pkg::PXB_W-1:0] portAPinOe,
  input wire logic [pxb_pkg::PXB_W-1:0] portDPinOe,
  input wire logic [pxb_pkg::PXB_W-1:0] portFPinOe,
  input wire logic                      writeStrobeN,
  input wire logic                      writeStrobeOe,
  input wire logic                      readStrobeN,
  input wire logic                      readStrobeOe,
  input wire logic                      addrLatch,
  input wire logic                      addrLatchOe,
  input wire logic                      busDone
);
  import pxb_pkg::*;
  default clocking cbSys @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence sStrobe(s);
    (!s)[*2] ##1 s;
  endsequence
  sequence sDone;
    busDone ##1 !busDone;
  endsequence
  AST_PORTA_DIR: assert property ($stable(portADirSel)[*3] |-> portAPinOe == portADirSel)
    else $error("port A enables differ from direction");
  AST_PORTD_BYTE: assert property ((!extMemSel && $stable(portDOutSel))[*3] |-> portDPinOe == {PXB_W{portDOutSel}})
    else $error("port D enables not byte wide");
  AST_FLOAT: assert property (!resetPinN || !hwStopN |-> ##[1:2] !(writeStrobeOe || readStrobeOe || addrLatchOe))
    else $error("strobes driven in reset or stop");
  AST_WR_LEN: assert property ($fell(writeStrobeN) |-> sStrobe(writeStrobeN))
    else $error("write strobe length wrong");
  AST_RD_LEN: assert property ($fell(readStrobeN) |-> sStrobe(readStrobeN))
    else $error("read strobe length wrong");
  AST_ALE_STROBE: assert property ($rose(addrLatch) |=> !addrLatch && (readStrobeN ^ writeStrobeN))
    else $error("latch pulse not followed by one strobe");
  AST_ALE_ADDR: assert property (addrLatch |-> portDPinOe == PXB_ALL_ONES && portFPinOe == PXB_ALL_ONES)
    else $error("address not driven at latch pulse");
  AST_WR_DRIVE: assert property (!writeStrobeN |-> portDPinOe == PXB_ALL_ONES && readStrobeN)
    else $error("data not driven in write");
  AST_RD_FREE: assert property (!readStrobeN |-> portDPinOe == PXB_DIR_RST && !addrLatch)
    else $error("bus driven in read");
  AST_DONE: assert property ($fell(readStrobeN) || $fell(writeStrobeN) |-> ##[1:2] sDone)
    else $error("done pulse missing after strobe");
endmodule : pxb_port_pins_properties

bind pxb_port_pins pxb_port_pins_properties i_pxb_port_pins_properties (
  .clk_sys, .reset, .resetPinN, .hwStopN, .portADirSel, .portDOutSel, .extMemSel, .portAPinOe, .portDPinOe,
  .portFPinOe, .writeStrobeN, .writeStrobeOe, .readStrobeN, .readStrobeOe, .addrLatch, .addrLatchOe, .busDone
);
`default_nettype wire

//--- testbench/pxb_port_pins_tb.sv
// Self-checking bench for the port pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module pxb_port_pins_tb;
  import pxb_pkg::*;
  logic clk_sys, reset = 1'b1, resetPinN = 1'b1, hwStopN = 1'b1, portDOutSel = 1'b0, extMemSel = 1'b0;
  logic serialClkIntSel = 1'b0, timerClkSel = 1'b0, serialTxData = 1'b0, serialClkOut = 1'b0, timerSquare = 1'b0;
  logic eventSquareA = 1'b0, eventSquareB = 1'b0, busReq = 1'b0, busWrite = 1'b0;
  logic [PXB_AW-1:0] busAddr = 16'h0000;
  logic [PXB_W-1:0] portADirSel = 8'h00, portAWrite = 8'h00, portBDirSel = 8'h00, portBWrite = 8'h00;
  logic [PXB_W-1:0] portCDirSel = 8'h00, portCAltSel = 8'h00, portCWrite = 8'h00, portDWrite = 8'h00;
  logic [PXB_W-1:0] portFDirSel = 8'h00, portFWrite = 8'h00, busWData = 8'h00, extPins = 8'h96, extC = 8'h96;
  logic [PXB_W-1:0] portAPinIn, portBPinIn, portCPinIn, portDPinIn, portFPinIn, memData, busRData;
  logic [PXB_W-1:0] portAPinOut, portAPinOe, portBPinOut, portBPinOe, portCPinOut, portCPinOe;
  logic [PXB_W-1:0] portDPinOut, portDPinOe, portFPinOut, portFPinOe;
  logic [PXB_W-1:0] portARead, portBRead, portCRead, portDRead, portFRead;
  logic writeStrobeN, writeStrobeOe, readStrobeN, readStrobeOe, addrLatch, addrLatchOe, busDone, busBusy;
  logic serialRxData, serialClkIn, edgeIrqTwo, edgeIrqTwoLevel, timerClockInput, eventCountInput;
  int mismatches = 0, checks = 0, cycles = 0, irqCount = 0, doneCount = 0;
  assign portAPinIn = portAPinOe & portAPinOut | ~portAPinOe & extPins;
  assign portBPinIn = portBPinOe & portBPinOut | ~portBPinOe & extPins;
  assign portCPinIn = portCPinOe & portCPinOut | ~portCPinOe & extC;
  assign portDPinIn = portDPinOe & portDPinOut | ~portDPinOe & memData;
  assign portFPinIn = portFPinOe & portFPinOut | ~portFPinOe & extPins;
  pxb_port_pins i_pxb_port_pins (
    .clk_sys, .reset, .resetPinN, .hwStopN, .portADirSel, .portAWrite, .portBDirSel, .portBWrite, .portCDirSel,
    .portCAltSel, .portCWrite, .portDOutSel, .portDWrite, .portFDirSel, .portFWrite, .extMemSel, .serialClkIntSel,
    .timerClkSel, .serialTxData, .serialClkOut, .timerSquare, .eventSquareA, .eventSquareB, .busReq, .busWrite,
    .busAddr, .busWData, .portAPinIn, .portBPinIn, .portCPinIn, .portDPinIn, .portFPinIn, .portAPinOut, .portAPinOe,
    .portBPinOut, .portBPinOe, .portCPinOut, .portCPinOe, .portDPinOut, .portDPinOe, .portFPinOut, .portFPinOe,
    .writeStrobeN, .writeStrobeOe, .readStrobeN, .readStrobeOe, .addrLatch, .addrLatchOe, .portARead, .portBRead,
    .portCRead, .portDRead, .portFRead, .serialRxData, .serialClkIn, .edgeIrqTwo, .edgeIrqTwoLevel,
    .timerClockInput, .eventCountInput, .busRData, .busDone, .busBusy
  );
  pxb_ext_mem i_pxb_ext_mem (.clk_sys, .portDPinOut, .portFPinOut, .addrLatch, .readStrobeN, .writeStrobeN, .memData);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    irqCount <= irqCount + int'(edgeIrqTwo === 1'b1);
    doneCount <= doneCount + int'(busDone === 1'b1);
    if (cycles == 1000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  task automatic t_reset();
    cyc(12);
    chk("enables in reset", {portAPinOe | portBPinOe | portCPinOe, portDPinOe | portFPinOe}, 16'h0000);
    reset = 1'b0;
    cyc(3);
    chk("enables after reset", {portAPinOe | portBPinOe | portCPinOe, portDPinOe | portFPinOe}, 16'h0000);
    chk("A read", portARead, extPins);
  endtask : t_reset
  task automatic t_float();
    chk("strobes", {writeStrobeOe, readStrobeOe, addrLatchOe, writeStrobeN, readStrobeN, addrLatch}, 6'h3E);
    resetPinN = 1'b0;
    cyc(2);
    chk("strobe enables", {writeStrobeOe, readStrobeOe, addrLatchOe}, 3'b000);
    resetPinN = 1'b1;
    cyc(3);
    chk("strobe enables", {writeStrobeOe, readStrobeOe, addrLatchOe}, 3'b111);
    hwStopN = 1'b0;
    cyc(2);
    chk("strobe enables", {writeStrobeOe, readStrobeOe, addrLatchOe}, 3'b000);
    hwStopN = 1'b1;
    cyc(3);
  endtask : t_float
  task automatic t_dir(input logic [PXB_W-1:0] d, input logic [PXB_W-1:0] w);
    {portADirSel, portBDirSel, portCDirSel, portFDirSel} = {4{d}};
    {portAWrite, portBWrite, portCWrite, portFWrite} = {4{w}};
    cyc(3);
    chk("A B enables", {portAPinOe, portBPinOe}, {d, d});
    chk("C F enables", {portCPinOe, portFPinOe}, {d, d});
    chk("A B drive", {portAPinOut & d, portBPinOut & d}, {w & d, w & d});
    chk("C F drive", {portCPinOut & d, portFPinOut & d}, {w & d, w & d});
    chk("A B read", {portARead, portBRead}, {2{w & d | extPins & ~d}});
    chk("C F read", {portCRead, portFRead}, {2{w & d | extPins & ~d}});
  endtask : t_dir
  task automatic t_portd();
    portDWrite = 8'h69;
    portDOutSel = 1'b1;
    cyc(3);
    chk("D enables", portDPinOe, 8'hFF);
    chk("D drive", {portDPinOut, portDRead}, 16'h6969);
    portDOutSel = 1'b0;
    cyc(3);
    chk("D enables", portDPinOe, 8'h00);
  endtask : t_portd
  task automatic t_alt();
    int irq0;
    portCDirSel = 8'h00;
    portCAltSel = 8'hFF;
    {serialClkIntSel, timerClkSel} = 2'b10;
    {serialTxData, serialClkOut, timerSquare, eventSquareA, eventSquareB} = 5'b11101;
    extC = 8'h28;
    cyc(3);
    irq0 = irqCount;
    chk("C enables", portCPinOe, 8'hD5);
    chk("C drive", portCPinOut & 8'hD5, 8'h95);
    chk("C inputs", {serialRxData, eventCountInput, edgeIrqTwoLevel}, 3'b011);
    {serialTxData, serialClkOut, timerSquare, eventSquareA, eventSquareB} = 5'b00010;
    extC = 8'h02;
    cyc(3);
    chk("C drive", portCPinOut & 8'hD5, 8'h40);
    chk("C inputs", {serialRxData, eventCountInput, edgeIrqTwoLevel}, 3'b100);
    chk("fall pulses", 16'(irqCount - irq0), 16'h0001);
    {serialClkIntSel, timerClkSel} = 2'b01;
    extC = 8'h0C;
    cyc(3);
    chk("C enables", portCPinOe, 8'hD1);
    chk("clock inputs", {serialClkIn, timerClockInput, edgeIrqTwo}, 3'b110);
    chk("fall pulses", 16'(irqCount - irq0), 16'h0001);
    extC = 8'h04;
    cyc(3);
    chk("timer clock low", {serialClkIn, timerClockInput}, 2'b10);
    chk("fall pulses", 16'(irqCount - irq0), 16'h0001);
    portCAltSel = 8'h00;
  endtask : t_alt
  task automatic bus_op(input logic w, input logic [15:0] a, input logic [7:0] d);
    int lowW = 0, lowR = 0, dones = 0, busy = 0;
    logic [15:0] lat = 16'h0000;
    {busReq, busWrite, busAddr, busWData} = {1'b1, w, a, d};
    cyc(1);
    busReq = 1'b0;
    repeat (7) begin
      if (addrLatch === 1'b1) lat = {portFPinOut, portDPinOut};
      lowW += int'(writeStrobeN === 1'b0);
      lowR += int'(readStrobeN === 1'b0);
      dones += int'(busDone === 1'b1);
      busy += int'(busBusy === 1'b1);
      cyc(1);
    end
    chk("latched address", lat, a);
    chk("strobe counts", {4'(lowW), 4'(lowR), 4'(dones), 4'(busy)}, w ? 16'h2013 : 16'h0213);
    if (!w) chk("read data", busRData, d);
  endtask : bus_op
  task automatic t_bus();
    int done0;
    extMemSel = 1'b1;
    cyc(3);
    bus_op(1'b1, 16'h12A7, 8'h5E);
    bus_op(1'b1, 16'h34A7, 8'hC1);
    bus_op(1'b0, 16'h12A7, 8'h5E);
    bus_op(1'b0, 16'h34A7, 8'hC1);
    extMemSel = 1'b0;
    cyc(3);
    done0 = doneCount;
    busReq = 1'b1;
    cyc(1);
    busReq = 1'b0;
    cyc(8);
    chk("refused request", 16'(doneCount - done0), 16'h0000);
  endtask : t_bus
  initial begin
    t_reset();
    t_float();
    t_dir(8'hA5, 8'h3C);
    t_dir(8'h5A, 8'hC3);
    t_portd();
    t_alt();
    t_bus();
    print_verdict();
  end
endmodule : pxb_port_pins_tb
`default_nettype wire
